// ==== bench/ebc_ext_mem.sv ====
// Behavioural memory on the far side of the external bus window.
// Assumes active low read strobe and one aclk per half oscillator period.
`default_nettype none
module ebc_ext_mem #(parameter int RDY_DLY = 5) (
    input  wire logic   aclk,
    input  wire logic   rd_n,
    input  wire logic   pol,
    output logic [15:0] ad,
    output logic        ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial ad = 16'h0000;
    initial ready = 1'b0;
    always @(posedge aclk) begin
        cnt <= rd_n ? 0 : cnt + 1;
        // Ready is slow on purpose, so a cycle ended early shows up.
        ready <= (!rd_n && cnt >= RDY_DLY) ? pol : !pol;
        // A released bus toggles, so stale data is never taken for an answer.
        ad <= rd_n ? ~ad : 16'h5a3c;
    end
endmodule // ebc_ext_mem
`default_nettype wire

// ==== bench/tb_external_bus_cycle_config.sv ====
// Self-checking bench for the external bus window block.
// Assumes the design answers AXI4-Lite and runs one request at a time.
`default_nettype none
module tb_external_bus_cycle_config
    import ebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic rqv = 0, rqw = 0, rqwin = 0, boot = 0, pol = 0;
    logic awr, wr_, bv, arr, rv, rqr, rsv, rse, ale, rdn, rdy, wln;
    logic [1:0]  br, rr, csn, port = 2'b11, be = 2'b11;
    logic [15:0] rsd, adi, rqd = 16'h0000;
    logic [19:0] aa = 0, ra = 0;
    logic [23:0] rqa = 24'h00_0000;
    logic [31:0] rd, wd = 0;
    int err_count = 0, checks_done = 0, cmd, gap, alen, tail, csx, ta;
    always #2.5 aclk = ~aclk;
    ebc_window_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .req_valid(rqv), .req_ready(rqr), .req_window(rqwin), .req_write(rqw),
        .req_addr(rqa), .req_wdata(rqd), .req_be(be), .resp_valid(rsv), .resp_err(rse),
        .resp_rdata(rsd), .external_boot_pin(boot), .boot_config_port(port),
        .ext_ready(rdy), .ext_ad_i(adi), .ext_ad_o(), .ext_ad_oe(), .ext_addr(),
        .ext_ale(ale), .ext_rd_n(rdn), .ext_store_strobe_low_n(wln),
        .ext_store_strobe_high_n(), .ext_cs_n(csn));
    ebc_ext_mem mem (.aclk(aclk), .rd_n(rdn), .pol(pol), .ad(adi), .ready(rdy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [19:0] a, input logic [15:0] d, input logic [1:0] er);
        logic [1:0] t;
        @(posedge aclk);
        aa <= a;
        wd <= {16'h0000, d};
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do begin
            @(negedge aclk);
            t = {awv & awr, wv & wr_};
            @(posedge aclk);
            if (t[1]) awv <= 0;
            if (t[0]) wv <= 0;
        end while ((awv & ~t[1]) | (wv & ~t[0]));
        do @(negedge aclk); while (!bv);
        chk({30'h0, br}, {30'h0, er});
        @(posedge aclk);
        bre <= 0;
    endtask
    task automatic axr(input logic [19:0] a, input logic [15:0] exp);
        @(posedge aclk);
        ra <= a;
        arv <= 1;
        rre <= 1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 0;
        do @(negedge aclk); while (!rv);
        chk(rd, {16'h0000, exp});
        @(posedge aclk);
        rre <= 0;
    endtask
    // Counts phases of one request; the window under test drives chip select bit 1.
    task automatic req(input logic w4);
        @(posedge aclk);
        rqwin <= w4;
        rqv <= 1;
        do @(negedge aclk); while (!rqr);
        @(posedge aclk);
        rqv <= 0;
        cmd = 0;
        gap = 0;
        alen = 0;
        tail = 0;
        csx = 0;
        do begin
            @(negedge aclk);
            cmd += !rdn || !wln;
            alen += ale;
            gap += (alen > 0 && cmd == 0 && !ale);
            tail += (cmd > 0 && rdn && !csn[1]);
            csx += (!csn[1] && rdn);
        end while (!rsv);
    endtask
    task automatic run(input logic [15:0] c, input int ec, input int ea, input int eg);
        axw(SETUP4_ADDR, c, RESP_OKAY);
        req(1'b1);
        chk(32'(cmd), 32'(ec));
        chk(32'(alen), 32'(ea));
        chk(32'(gap), 32'(eg));
        chk({31'h0, rse}, 32'h0000_0000);
        chk(32'(csx == 0), 32'(c[14]));
    endtask
    task automatic final_report();
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        axr(SETUP0_ADDR, 16'h06c0);
        axr(SETUP4_ADDR, 16'h00c0);
        axw(SETUP4_ADDR, 16'hffff, RESP_OKAY);
        axr(SETUP4_ADDR, 16'hf6ff);
        axw(20'h0_0010, 16'h1234, RESP_SLVERR);
        run(16'h04ff, 2, 1, 0);
        ta = tail;
        run(16'h04df, 2, 1, 0);
        chk(32'(tail - ta), 32'h0000_0002);
        run(16'h46ed, 6, 2, 1);
        chk({16'h0000, rsd}, 32'h0000_5a3c);
        axw(SETUP4_ADDR, 16'h14ff, RESP_OKAY);
        req(1'b1);
        chk(32'(cmd > 5), 32'h0000_0001);
        pol <= 1;
        axw(SETUP4_ADDR, 16'h34ff, RESP_OKAY);
        req(1'b1);
        chk(32'(cmd > 5), 32'h0000_0001);
        axw(SETUP4_ADDR, 16'h84ff, RESP_OKAY);
        rqw <= 1;
        req(1'b1);
        chk(32'(cmd), 32'h0000_0002);
        chk(32'(csx), 32'h0000_0002);
        axw(SETUP0_ADDR, 16'h0000, RESP_OKAY);
        req(1'b0);
        chk({31'h0, rse}, 32'h0000_0001);
        final_report();
    end
endmodule // tb_external_bus_cycle_config
`default_nettype wire

// ==== logic/ebc_cycle_engine.sv ====
// Sequencer for one external bus cycle: latch, delay, command, tristate.
// Assumes cfg, write and be stay stable from start until idle returns.
`default_nettype none

module ebc_cycle_engine
    import ebc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic [1:0]  be,
    input  wire logic [15:0] cfg,
    input  wire logic        ready_sync,
    output logic             ale,
    output logic             rd_n,
    output logic             store_strobe_low_n,
    output logic             store_strobe_high_n,
    output logic             cs_n,
    output logic             cmd_phase,
    output logic             idle,
    output logic             sample,
    output logic             done
);

    typedef struct packed {
        ebc_phase_t  ph;
        logic [5:0]  cnt;
        logic        sample;
        logic        done;
    } ebc_eng_st_t;

    ebc_eng_st_t r;
    ebc_eng_st_t n;
    logic [5:0]  waits;
    logic [5:0]  cmd_len;
    logic        rdy_act;
    logic        bus8;
    logic        gated;

    assign waits   = 6'(WCNT_NONE - cfg[F_WCNT +: 4]);
    assign cmd_len = 6'(CMD_BASE_CYC + 6'(waits * WAIT_CYC));
    assign rdy_act = (ready_sync == cfg[F_HPOL]);
    assign bus8    = !cfg[F_KIND + 1];

    always_comb begin
        n        = r;
        n.sample = 1'b0;
        n.done   = 1'b0;
        unique case (r.ph)
            PH_IDLE: begin
                if (start) begin
                    n.ph  = PH_ALE;
                    n.cnt = cfg[F_LSTR] ? ALE_LONG_CYC - 6'd1
                                          : ALE_CYC - 6'd1;
                end
            end
            PH_ALE: begin
                if (r.cnt != 6'd0) begin
                    n.cnt = r.cnt - 6'd1;
                end else if (cfg[F_CDLY]) begin
                    n.ph  = PH_CMD;
                    n.cnt = cmd_len - 6'd1;
                end else begin
                    n.ph  = PH_DLY;
                    n.cnt = HALF_CYC - 6'd1;
                end
            end
            PH_DLY: begin
                if (r.cnt != 6'd0) begin
                    n.cnt = r.cnt - 6'd1;
                end else begin
                    n.ph  = PH_CMD;
                    n.cnt = cfg[F_HSEN] ? CMD_BASE_CYC - 6'd1 : cmd_len - 6'd1;
                end
            end
            PH_CMD: begin
                if (r.cnt != 6'd0) begin
                    n.cnt = r.cnt - 6'd1;
                end else if (!cfg[F_HSEN] || rdy_act) begin
                    n.sample = 1'b1;
                    n.ph     = cfg[F_TRIW] ? PH_IDLE : PH_TRI;
                    n.cnt    = WAIT_CYC - 6'd1;
                    n.done   = cfg[F_TRIW];
                end
            end
            PH_TRI: begin
                if (r.cnt != 6'd0) begin
                    n.cnt = r.cnt - 6'd1;
                end else begin
                    n.ph   = PH_IDLE;
                    n.done = 1'b1;
                end
            end
            default: begin
                n.ph = PH_IDLE;
            end
        endcase
        if (!aresetn) begin
            n    = '0;
            n.ph = PH_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        r <= n;
    end

    // A gated select follows its strobe; otherwise it spans the cycle.
    assign gated               = write ? cfg[F_SELST] : cfg[F_SELRD];
    assign cmd_phase           = (r.ph == PH_CMD);
    assign ale                 = (r.ph == PH_ALE);
    assign idle                = (r.ph == PH_IDLE);
    assign rd_n                = !(cmd_phase && !write);
    assign store_strobe_low_n  = !(cmd_phase && write && (bus8 || be[0]));
    assign store_strobe_high_n = !(cmd_phase && write && !bus8 && be[1]);
    assign cs_n                = gated ? !cmd_phase : idle;
    assign sample              = r.sample;
    assign done                = r.done;

endmodule : ebc_cycle_engine

`default_nettype wire

// ==== logic/ebc_pkg.sv ====
// Constants and types shared by the external bus window block.
// Assumes one aclk cycle stands for one half oscillator period.
`default_nettype none

package ebc_pkg;

    // ************************************************************
    // Register map and layout.
    // ************************************************************
    localparam logic [15:0] SETUP4_IDX  = 16'hff1a;
    localparam logic [19:0] SETUP4_ADDR = {2'b00, SETUP4_IDX, 2'b00};
    localparam logic [19:0] SETUP0_ADDR = 20'h0_0000;
    localparam logic [19:0] STATUS_ADDR = 20'h0_0004;
    localparam logic [15:0] SETUP_RST   = 16'h0000;
    localparam logic [15:0] SETUP_WMASK = 16'hf6ff;
    localparam logic [3:0]  WCNT_NONE   = 4'hf;
    localparam int F_WCNT   = 0;
    localparam int F_CDLY   = 4;
    localparam int F_TRIW   = 5;
    localparam int F_KIND   = 6;
    localparam int F_LSTR   = 9;
    localparam int F_WACT   = 10;
    localparam int F_HSEN   = 12;
    localparam int F_HPOL   = 13;
    localparam int F_SELRD  = 14;
    localparam int F_SELST  = 15;
    localparam int S_BUSY   = 0;
    localparam int S_ERR    = 1;
    localparam int S_BOOT   = 2;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ************************************************************
    // Cycle timing.
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HALF_PS       = 5000;
    localparam logic [5:0] HALF_CYC =
        6'((HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [5:0] ALE_CYC      = HALF_CYC;
    localparam logic [5:0] ALE_LONG_CYC = 6'(2 * HALF_CYC);
    localparam logic [5:0] CMD_BASE_CYC = 6'(2 * HALF_CYC);
    localparam logic [5:0] WAIT_CYC     = 6'(2 * HALF_CYC);

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ALE  = 3'b001,
        PH_DLY  = 3'b010,
        PH_CMD  = 3'b011,
        PH_TRI  = 3'b100
    } ebc_phase_t;

endpackage : ebc_pkg

`default_nettype wire

// ==== logic/ebc_window_ctrl.sv ====
// Window setup registers, boot loading and external bus request front end.
// Assumes an AXI4-Lite master on aclk and asynchronous external pins.
//
// Contract
// - Wait states equal fifteen minus the four-bit wait count.
// - Command delay bit zero delays the command one half period after latch.
// - Tristate bit zero adds one tristate wait state.
// - Bus kind selects 8/16-bit and multiplexed or demultiplexed cycles.
// - Bus kind loads from the boot port at the end of reset; for window zero only with boot pin low.
// - Window zero resets to zero or, boot pin low, active with long latch.
// - Latch stretch bit one lengthens the address latch strobe.
// - Bus active bit zero disables external cycles for that window.
// - Handshake enable zero times cycles by the wait count only.
// - Ready input ends the cycle at the level the polarity bit picks.
// - Select on read gates chip select to the read strobe.
// - Select on store gates chip select to the store strobes.
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none

module ebc_window_ctrl
    import ebc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [19:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [19:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_window,
    input  wire logic        req_write,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic [1:0]  req_be,
    output logic             resp_valid,
    output logic             resp_err,
    output logic [15:0]      resp_rdata,
    input  wire logic        external_boot_pin,
    input  wire logic [1:0]  boot_config_port,
    input  wire logic        ext_ready,
    input  wire logic [15:0] ext_ad_i,
    output logic [15:0]      ext_ad_o,
    output logic             ext_ad_oe,
    output logic [23:0]      ext_addr,
    output logic             ext_ale,
    output logic             ext_rd_n,
    output logic             ext_store_strobe_low_n,
    output logic             ext_store_strobe_high_n,
    output logic [1:0]       ext_cs_n
);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [15:0] setup0;
        logic [15:0] setup4;
        logic        boot_done;
        logic        ebp_s1;
        logic        ebp_s2;
        logic [1:0]  bcp_s1;
        logic [1:0]  bcp_s2;
        logic        rdy_s1;
        logic        rdy_s2;
        logic [15:0] dat_s1;
        logic [15:0] dat_s2;
        logic        aw_have;
        logic [19:0] aw_addr;
        logic        w_have;
        logic [15:0] w_data;
        logic [1:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        busy;
        logic        start;
        logic        fin;
        logic        got;
        logic        last_err;
        logic        cur_win;
        logic        cur_write;
        logic [1:0]  cur_be;
        logic [15:0] cur_cfg;
        logic [15:0] cur_wdata;
        logic [23:0] cur_addr;
        logic        cap;
        logic [15:0] rd_hold;
        logic        resp_valid;
        logic        resp_err;
        logic [15:0] resp_rdata;
        logic [5:0]  cmd_cnt;
    } ebc_top_st_t;

    ebc_top_st_t r;
    ebc_top_st_t n;
    logic        fire;
    logic [15:0] sel_cfg;
    logic [15:0] wr_val0;
    logic [15:0] wr_val4;
    logic [19:0] wa;
    logic [19:0] ra;
    logic        bus8;
    logic        eng_ale;
    logic        eng_rd_n;
    logic        eng_stl_n;
    logic        eng_sth_n;
    logic        eng_cs_n;
    logic        eng_cmd;
    logic        eng_idle;
    logic        eng_sample;
    logic        eng_done;

    assign s_axi_awready = !r.aw_have && !r.bvalid;
    assign s_axi_wready  = !r.w_have && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign req_ready     = r.boot_done && !r.busy;
    assign fire          = req_valid && req_ready;
    assign sel_cfg       = req_window ? r.setup4 : r.setup0;
    assign wa            = {r.aw_addr[19:2], 2'b00};
    assign ra            = {s_axi_araddr[19:2], 2'b00};
    assign bus8          = !r.cur_cfg[F_KIND + 1];

    // Unused bits are masked on the way in, so they always read zero.
    assign wr_val0 = {r.w_strb[1] ? r.w_data[15:8] : r.setup0[15:8],
                      r.w_strb[0] ? r.w_data[7:0] : r.setup0[7:0]} & SETUP_WMASK;
    assign wr_val4 = {r.w_strb[1] ? r.w_data[15:8] : r.setup4[15:8],
                      r.w_strb[0] ? r.w_data[7:0] : r.setup4[7:0]} & SETUP_WMASK;

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        n            = r;
        n.start      = 1'b0;
        n.resp_valid = 1'b0;
        n.cap        = eng_sample;
        n.ebp_s1     = external_boot_pin;
        n.ebp_s2     = r.ebp_s1;
        n.bcp_s1     = boot_config_port;
        n.bcp_s2     = r.bcp_s1;
        n.rdy_s1     = ext_ready;
        n.rdy_s2     = r.rdy_s1;
        n.dat_s1     = ext_ad_i;
        n.dat_s2     = r.dat_s1;
        n.cmd_cnt    = eng_cmd ? r.cmd_cnt + 6'd1 : 6'd0;

        // The pins are caught in the first cycle after reset is released.
        if (!r.boot_done) begin
            n.boot_done           = 1'b1;
            n.setup4[F_KIND +: 2] = r.bcp_s2;
            if (!r.ebp_s2) begin
                n.setup0[F_WACT]      = 1'b1;
                n.setup0[F_LSTR]      = 1'b1;
                n.setup0[F_KIND +: 2] = r.bcp_s2;
            end
        end

        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_have = 1'b1;
            n.w_data = s_axi_wdata[15:0];
            n.w_strb = s_axi_wstrb[1:0];
        end
        if (r.aw_have && r.w_have) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            if (wa == SETUP0_ADDR) begin
                n.setup0 = wr_val0;
            end else if (wa == SETUP4_ADDR) begin
                n.setup4 = wr_val4;
            end else if (wa != STATUS_ADDR) begin
                n.bresp = RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            if (ra == SETUP0_ADDR) begin
                n.rdata[15:0] = r.setup0;
            end else if (ra == SETUP4_ADDR) begin
                n.rdata[15:0] = r.setup4;
            end else if (ra == STATUS_ADDR) begin
                n.rdata[S_BUSY] = r.busy;
                n.rdata[S_ERR]  = r.last_err;
                n.rdata[S_BOOT] = r.boot_done;
            end else begin
                n.rresp = RESP_SLVERR;
            end
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end

        if (fire) begin
            if (sel_cfg[F_WACT]) begin
                n.busy      = 1'b1;
                n.start     = 1'b1;
                n.cur_win   = req_window;
                n.cur_write = req_write;
                n.cur_be    = req_be;
                n.cur_cfg   = sel_cfg;
                n.cur_wdata = req_wdata;
                n.cur_addr  = req_addr;
            end else begin
                n.resp_valid = 1'b1;
                n.resp_err   = 1'b1;
                n.resp_rdata = 16'h0000;
                n.last_err   = 1'b1;
            end
        end

        // Read data crosses two flip-flops, so it is taken one cycle late.
        if (r.cap) begin
            n.got     = 1'b1;
            n.rd_hold = (bus8 && r.cur_be == 2'b10) ? {r.dat_s2[7:0], r.dat_s2[7:0]}
                                                     : r.dat_s2;
        end
        if (eng_done) begin
            n.fin = 1'b1;
        end
        if (r.fin && r.got) begin
            n.fin        = 1'b0;
            n.got        = 1'b0;
            n.busy       = 1'b0;
            n.resp_valid = 1'b1;
            n.resp_err   = 1'b0;
            n.last_err   = 1'b0;
            n.resp_rdata = r.cur_write ? 16'h0000 : r.rd_hold;
        end

        if (!aresetn) begin
            n        = '0;
            n.setup0 = SETUP_RST;
            n.setup4 = SETUP_RST;
            n.ebp_s1 = external_boot_pin;
            n.ebp_s2 = r.ebp_s1;
            n.bcp_s1 = boot_config_port;
            n.bcp_s2 = r.bcp_s1;
        end
    end

    always_ff @(posedge aclk) begin
        r <= n;
    end

    // ************************************************************
    // Bus cycle engine and pins.
    // ************************************************************
    ebc_cycle_engine u_engine (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .start               (r.start),
        .write               (r.cur_write),
        .be                  (r.cur_be),
        .cfg                 (r.cur_cfg),
        .ready_sync          (r.rdy_s2),
        .ale                 (eng_ale),
        .rd_n                (eng_rd_n),
        .store_strobe_low_n  (eng_stl_n),
        .store_strobe_high_n (eng_sth_n),
        .cs_n                (eng_cs_n),
        .cmd_phase           (eng_cmd),
        .idle                (eng_idle),
        .sample              (eng_sample),
        .done                (eng_done)
    );

    // A multiplexed bus carries the low address on the data lines first.
    assign ext_ad_o = (r.cur_cfg[F_KIND] && eng_ale) ? r.cur_addr[15:0] :
                      (bus8 && !r.cur_be[0]) ? {8'h00, r.cur_wdata[15:8]} :
                      r.cur_wdata;
    assign ext_ad_oe = (r.cur_cfg[F_KIND] && eng_ale) || (r.cur_write && eng_cmd);
    assign ext_addr                = r.cur_addr;
    assign ext_ale                 = eng_ale;
    assign ext_rd_n                = eng_rd_n;
    assign ext_store_strobe_low_n  = eng_stl_n;
    assign ext_store_strobe_high_n = eng_sth_n;
    assign ext_cs_n                = {r.cur_win ? eng_cs_n : 1'b1,
                                      r.cur_win ? 1'b1 : eng_cs_n};
    assign s_axi_bvalid            = r.bvalid;
    assign s_axi_bresp             = r.bresp;
    assign s_axi_rvalid            = r.rvalid;
    assign s_axi_rdata             = r.rdata;
    assign s_axi_rresp             = r.rresp;
    assign resp_valid              = r.resp_valid;
    assign resp_err                = r.resp_err;
    assign resp_rdata              = r.resp_rdata;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [5:0] exp_cmd;
    assign exp_cmd = 6'(CMD_BASE_CYC + 6'(6'(WCNT_NONE - r.cur_cfg[3:0]) * WAIT_CYC));

    wait_len_a: assert property ($fell(eng_cmd) && !r.cur_cfg[F_HSEN] |->
        r.cmd_cnt == exp_cmd) else $error("command length differs from wait count");
    cmd_delay_a: assert property ($fell(eng_ale) && !r.cur_cfg[F_CDLY] |->
        !eng_cmd ##1 eng_cmd) else $error("delayed command timing wrong");
    cmd_nodelay_a: assert property ($fell(eng_ale) && r.cur_cfg[F_CDLY] |->
        eng_cmd) else $error("undelayed command timing wrong");
    tri_wait_a: assert property ($fell(eng_cmd) && !r.cur_cfg[F_TRIW] |->
        !eng_idle ##1 !eng_idle ##1 eng_idle) else $error("tristate wait wrong");
    mux_addr_a: assert property (ext_ale && !r.cur_cfg[F_KIND] |->
        !ext_ad_oe) else $error("demultiplexed bus drives address on data lines");
    boot_load_a: assert property (!r.boot_done ##1 r.boot_done |->
        r.setup0[F_WACT] == !$past(r.ebp_s2) && r.setup4[F_KIND +: 2] == $past(r.bcp_s2))
        else $error("boot configuration not loaded");
    ale_long_a: assert property ($rose(ext_ale) && r.cur_cfg[F_LSTR] |->
        ext_ale ##1 ext_ale ##1 !ext_ale) else $error("latch strobe not lengthened");
    ale_short_a: assert property ($rose(ext_ale) && !r.cur_cfg[F_LSTR] |->
        ##1 !ext_ale) else $error("latch strobe too long");
    win_off_a: assert property (fire && !sel_cfg[F_WACT] |->
        ##1 (resp_valid && resp_err && eng_idle)) else $error("inactive window ran a cycle");
    rdy_hold_a: assert property (eng_cmd && r.cur_cfg[F_HSEN] &&
        r.rdy_s2 != r.cur_cfg[F_HPOL] |=> eng_cmd) else $error("cycle ended without ready");
    cs_read_a: assert property (!r.cur_write && r.cur_cfg[F_SELRD] &&
        ext_cs_n != 2'b11 |-> !ext_rd_n) else $error("select outside read strobe");
    cs_write_a: assert property (r.cur_write && r.cur_cfg[F_SELST] &&
        ext_cs_n != 2'b11 |-> eng_cmd) else $error("select outside store strobe");
    rsvd_zero_a: assert property ($rose(s_axi_bvalid) |->
        !r.setup0[11] && !r.setup0[8] && !r.setup4[11] && !r.setup4[8])
        else $error("reserved setup bit set");

    read_cyc_c: cover property (fire && !req_write ##[1:60] resp_valid && !resp_err);
    write_cyc_c: cover property (fire && req_write ##[1:60] resp_valid);
    rdy_ext_c: cover property (eng_cmd && r.cur_cfg[F_HSEN] ##1 eng_cmd ##1 eng_cmd);

endmodule : ebc_window_ctrl

`default_nettype wire
